// [smbat_defs.svh]
// constants of the smbus alert, timeout and interrupt merge block
// assumes a 100 MHz system clock; included by the package only, the modules use its macros
`ifndef SMBAT_DEFS_SVH
`define SMBAT_DEFS_SVH

// clock and timing
`define SMBAT_CLK_KHZ 100000
`define SMBAT_TLOW_MS 35
`define SMBAT_TLOW_CYC (`SMBAT_TLOW_MS * `SMBAT_CLK_KHZ)
`define SMBAT_TCNT_W 22
`define SMBAT_FMAX_KHZ 100
`define SMBAT_FMIN_KHZ 10
`define SMBAT_HALF_MIN \
    ((`SMBAT_CLK_KHZ + 2 * `SMBAT_FMAX_KHZ - 1) / (2 * `SMBAT_FMAX_KHZ))
`define SMBAT_HALF_MAX (`SMBAT_CLK_KHZ / (2 * `SMBAT_FMIN_KHZ))

// register byte offsets
`define SMBAT_OFS_CTRL 5'h00
`define SMBAT_OFS_IRQEN 5'h04
`define SMBAT_OFS_STAT 5'h08
`define SMBAT_OFS_OWN 5'h0C
`define SMBAT_OFS_DIV 5'h10

// control bits
`define SMBAT_C_EN 0
`define SMBAT_C_SMB 1
`define SMBAT_C_HOST 2
`define SMBAT_C_ARP 3
`define SMBAT_C_ALERT 4
`define SMBAT_C_STOP 5
`define SMBAT_C_FRZ 6

// interrupt enable bits
`define SMBAT_I_EVT 0
`define SMBAT_I_BUF 1
`define SMBAT_I_ERR 2

// status bits
`define SMBAT_S_RXF 5
`define SMBAT_S_TXE 6
`define SMBAT_S_TMO 12
`define SMBAT_S_ALERT 13
`define SMBAT_S_HOSTM 14
`define SMBAT_S_DFLTM 15
`define SMBAT_W1C_MASK 16'hFF9F

// reset values and bus addresses
`define SMBAT_CTRL_RST 7'h00
`define SMBAT_OWN_RST 7'h00
`define SMBAT_ARA 7'h0C
`define SMBAT_DFLT_ADDR 7'h61
`define SMBAT_HOST_HDR 7'h08

`endif

// [smbat_pkg.sv]
// types of the smbus alert, timeout and interrupt merge block
// assumes the constants header sits beside it
`include "smbat_defs.svh"
package smbat_pkg;

    // link monitor states, gray along idle-addr-ack-send-mack
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ADDR = 3'h1,
        S_ACK = 3'h3,
        S_SEND = 3'h2,
        S_MACK = 3'h6
    } smbat_mon_type;

    typedef struct packed {
        logic [6:0] ctrl;
        logic [2:0] irqen;
        logic [15:0] stat;
        logic [6:0] own;
        logic [12:0] div;
        logic [12:0] dcnt;
        logic tick;
        logic wait_r;
        logic [31:0] rdata;
        logic scl_p;
        logic sda_p;
        smbat_mon_type st;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic ara_rd;
        logic sda_oe_n;
        logic alert_oe_n;
        logic evt_irq;
        logic err_irq;
    } smbat_top_type;

    typedef struct packed {
        logic [`SMBAT_TCNT_W-1:0] cnt;
        logic expired;
    } smbat_tmo_type;

endpackage

// [smbat_tmo_if.sv]
// carrier between the block top and its clock-low timeout counter
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface smbat_tmo_if;
    logic run;
    logic scl_low;
    logic freeze;
    logic expired;
    modport ctl (output run, output scl_low, output freeze,
        input expired);
    modport cnt (input run, input scl_low, input freeze,
        output expired);
endinterface
`default_nettype wire

// [smbat_sync.sv]
// two-stage synchroniser for pins sampled by the system clock
// assumes inputs are asynchronous levels; only s2 is read outside
`timescale 1ns/1ps
`default_nettype none
module smbat_sync #(
    parameter int W = 3
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } smbat_sync_type;
    smbat_sync_type r, n;

    // idle open-drain lines rest high
    always_comb
    begin
        n = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            r <= '1;
        else
            r <= n;
    end

    assign q = r.s2;
endmodule
`default_nettype wire

// [smbat_tmo.sv]
// clock-low timeout counter, one expiry pulse per low stretch
// assumes scl_low comes from a synchronised pin
`timescale 1ns/1ps
`default_nettype none
module smbat_tmo
    import smbat_pkg::*;
#(
    parameter int TLOW_CYC = `SMBAT_TLOW_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    smbat_tmo_if.cnt t
);
    localparam logic [`SMBAT_TCNT_W-1:0] LIM =
        `SMBAT_TCNT_W'(TLOW_CYC);
    smbat_tmo_type r, n;

    // count while low, restart on high, hold on debug freeze
    always_comb
    begin
        n = r;
        n.expired = 1'h0;
        if (!t.run || !t.scl_low)
            n.cnt = '0; // RULE_23
        else if (t.freeze)
            n.cnt = r.cnt; // RULE_17
        else if (r.cnt < LIM)
        begin
            n.cnt = r.cnt + `SMBAT_TCNT_W'(1);
            n.expired = (r.cnt == LIM - `SMBAT_TCNT_W'(1)); // RULE_02
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            r <= '0;
        else
            r <= n;
    end

    assign t.expired = r.expired;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    AST_TMO_FREEZE: assert property ( // RULE_17
        t.run && t.scl_low && t.freeze ##1 t.run && t.scl_low
        && t.freeze |-> $stable(r.cnt))
        else $error("timeout count moved while frozen");
    AST_TMO_RESTART: assert property ( // RULE_23
        !t.scl_low |=> r.cnt == '0 && !r.expired)
        else $error("timeout count not restarted on high clock");
endmodule
`default_nettype wire

// [smbat_top.sv]
// smbus alert, clock-low timeout and interrupt merge, avalon-mm slave
// assumes the byte engine feeds event and error pulses on clk_sys
// Operation
// RULE_01 - quick command gets no special handling; only addressed bytes.
// RULE_02 - clock line low beyond 35 ms is a bus fault.
// RULE_03 - timeout sets a sticky status flag for software.
// RULE_04 - generated master clock stays within 10 to 100 kHz.
// RULE_05 - software sets alert request, pulling the alert line low.
// RULE_06 - host addresses alert response address 0001100, any direction.
// RULE_07 - only a device driving alert acknowledges the response address.
// RULE_08 - alert line low sets an alert status flag; the code sets it in host type only.
// RULE_09 - alert reply byte holds own address in upper seven bits.
// RULE_10 - address arbitration decides among several alerting devices.
// RULE_11 - after delivering its address the device releases alert.
// RULE_12 - host reads response address again while alert stays low.
// RULE_13 - software enables smbus mode, then type and resolution.
// RULE_14 - resolution on, device type: acknowledge default device address.
// RULE_15 - resolution on, host type: recognise host header address.
// RULE_16 - host header and default address matches set status flags.
// RULE_17 - debug control freezes the timeout counter while halted.
// RULE_18 - event interrupt ORs five event flags, gated by enable.
// RULE_19 - buffer flags need both event and buffer enables.
// RULE_20 - fault interrupt ORs seven error flags, gated by enable.
// RULE_21 - timeout sets the stop request to release the bus.
// RULE_22 - disabling clears alert request; released alert gives no ack.
// RULE_23 - timeout counts clocks while line low, restarting on high.
`timescale 1ns/1ps
`default_nettype none
module smbat_top
    import smbat_pkg::*;
#(
    parameter int TLOW_CYC = `SMBAT_TLOW_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic alert_i,
    output logic alert_o,
    output logic alert_oe_n,
    input wire logic [4:0] evt_set,
    input wire logic [4:0] err_set,
    input wire logic rx_buffer_full_flag,
    input wire logic tx_buffer_empty_flag,
    input wire logic debug_halt,
    output logic stop_request,
    output logic scl_tick,
    output logic event_irq,
    output logic fault_irq
);
    smbat_top_type r, n;
    smbat_tmo_if tif ();
    logic [2:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic alert_s;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic mon_on;
    logic addr_done;
    logic ara_hit;
    logic dflt_hit;
    logic host_hit;
    logic [15:0] sets;

    // word decode shared by the read and write paths
    function automatic logic sel(input logic [4:0] a,
        input logic [4:0] ofs);
        sel = (a[4:2] == ofs[4:2]) && (a[1:0] == 2'h0);
    endfunction

    smbat_sync #(.W(3)) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d({scl_i, sda_i, alert_i}),
        .q(pins_s)
    );

    smbat_tmo #(.TLOW_CYC(TLOW_CYC)) u_tmo (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .t(tif)
    );

    // link edges and conditions, all from synchronised samples
    assign scl_s = pins_s[2];
    assign sda_s = pins_s[1];
    assign alert_s = pins_s[0];
    assign rise = scl_s && !r.scl_p;
    assign fall = !scl_s && r.scl_p;
    assign start_c = scl_s && r.scl_p && r.sda_p && !sda_s;
    assign stop_c = scl_s && r.scl_p && !r.sda_p && sda_s;
    assign mon_on = r.ctrl[`SMBAT_C_EN] && r.ctrl[`SMBAT_C_SMB];

    // timeout counter hookup
    assign tif.run = mon_on;
    assign tif.scl_low = !scl_s;
    assign tif.freeze = debug_halt && r.ctrl[`SMBAT_C_FRZ]; // RULE_17

    // address byte complete at the falling clock edge after the eighth rising edge
    assign addr_done = r.st == S_ADDR && fall && r.bcnt == 4'h8;
    assign ara_hit = addr_done && r.ctrl[`SMBAT_C_ALERT]
        && r.sh[7:1] == `SMBAT_ARA; // RULE_07
    assign dflt_hit = addr_done && r.ctrl[`SMBAT_C_ARP]
        && !r.ctrl[`SMBAT_C_HOST]
        && r.sh[7:1] == `SMBAT_DFLT_ADDR; // RULE_14
    assign host_hit = addr_done && r.ctrl[`SMBAT_C_ARP]
        && r.ctrl[`SMBAT_C_HOST]
        && r.sh[7:1] == `SMBAT_HOST_HDR; // RULE_15

    // hardware flag sets, applied after software clears so they win
    assign sets = {dflt_hit, host_hit,
        mon_on && r.ctrl[`SMBAT_C_HOST] && !alert_s, // RULE_08
        tif.expired, err_set, 2'h0, evt_set}; // RULE_03 RULE_16

    always_comb
    begin
        n = r;
        n.tick = 1'h0;
        n.scl_p = scl_s;
        n.sda_p = sda_s;

        // bus slave: one wait cycle, then the access completes
        if ((avs_read || avs_write) && r.wait_r)
        begin
            n.wait_r = 1'h0;
            n.rdata = 32'h0000_0000;
            if (sel(avs_address, `SMBAT_OFS_CTRL))
                n.rdata[6:0] = r.ctrl;
            else if (sel(avs_address, `SMBAT_OFS_IRQEN))
                n.rdata[2:0] = r.irqen;
            else if (sel(avs_address, `SMBAT_OFS_STAT))
            begin
                n.rdata[15:0] = r.stat;
                n.rdata[`SMBAT_S_RXF] = rx_buffer_full_flag;
                n.rdata[`SMBAT_S_TXE] = tx_buffer_empty_flag;
            end
            else if (sel(avs_address, `SMBAT_OFS_OWN))
                n.rdata[6:0] = r.own;
            else if (sel(avs_address, `SMBAT_OFS_DIV))
                n.rdata[12:0] = r.div;
        end
        else if (avs_read || avs_write)
        begin
            n.wait_r = 1'h1;
            if (avs_write && sel(avs_address, `SMBAT_OFS_CTRL))
                n.ctrl = avs_writedata[6:0]; // RULE_05 RULE_13
            else if (avs_write && sel(avs_address, `SMBAT_OFS_IRQEN))
                n.irqen = avs_writedata[2:0];
            else if (avs_write && sel(avs_address, `SMBAT_OFS_STAT))
                n.stat = r.stat & ~(avs_writedata[15:0]
                    & `SMBAT_W1C_MASK);
            else if (avs_write && sel(avs_address, `SMBAT_OFS_OWN))
                n.own = avs_writedata[6:0];
            else if (avs_write && sel(avs_address, `SMBAT_OFS_DIV))
            begin
                // clamp the half period so the clock stays legal
                if (avs_writedata[12:0] < 13'(`SMBAT_HALF_MIN))
                    n.div = 13'(`SMBAT_HALF_MIN); // RULE_04
                else if (avs_writedata[12:0] > 13'(`SMBAT_HALF_MAX))
                    n.div = 13'(`SMBAT_HALF_MAX); // RULE_04
                else
                    n.div = avs_writedata[12:0];
            end
        end

        // sticky flags: set beats a same-cycle clear
        n.stat = n.stat | sets;

        // half-period tick for the byte engine's master clock
        if (!r.ctrl[`SMBAT_C_EN] || r.dcnt >= r.div - 13'h1)
            n.dcnt = 13'h0;
        else
            n.dcnt = r.dcnt + 13'h1;
        n.tick = r.ctrl[`SMBAT_C_EN] && r.dcnt >= r.div - 13'h1;

        // timeout forces a stop request; a stop on the bus clears it
        if (stop_c)
            n.ctrl[`SMBAT_C_STOP] = 1'h0;
        if (tif.expired)
            n.ctrl[`SMBAT_C_STOP] = 1'h1; // RULE_21

        // link monitor for the smbus-specific addresses
        unique case (r.st)
            S_IDLE:
                n.st = S_IDLE;
            S_ADDR:
                if (rise && r.bcnt != 4'h8)
                begin
                    n.sh = {r.sh[6:0], sda_s};
                    n.bcnt = r.bcnt + 4'h1;
                end
                else if (addr_done)
                begin
                    // a quick command simply ends at stop after this ack
                    if (ara_hit || dflt_hit || host_hit)
                    begin
                        n.sda_oe_n = 1'h0; // RULE_06 RULE_14
                        n.st = S_ACK;
                        n.ara_rd = ara_hit && r.sh[0]; // RULE_01
                    end
                    else
                        n.st = S_IDLE; // RULE_22
                end
            S_ACK:
                if (fall && r.ara_rd)
                begin
                    // first reply bit goes out right after the ack
                    n.st = S_SEND;
                    n.bcnt = 4'h0;
                    n.tx = {r.own, 1'h0}; // RULE_09
                    n.sda_oe_n = r.own[6];
                end
                else if (fall)
                begin
                    n.sda_oe_n = 1'h1;
                    n.st = S_IDLE;
                end
            S_SEND:
                if (rise && r.tx[7] && !sda_s)
                begin
                    // a smaller address pulled low: we lost, back off
                    n.sda_oe_n = 1'h1; // RULE_10
                    n.st = S_IDLE;
                end
                else if (rise)
                    n.bcnt = r.bcnt + 4'h1;
                else if (fall && r.bcnt == 4'h8)
                begin
                    n.sda_oe_n = 1'h1;
                    n.st = S_MACK;
                end
                else if (fall)
                begin
                    n.tx = {r.tx[6:0], 1'h0};
                    n.sda_oe_n = r.tx[6];
                end
            S_MACK:
                if (rise)
                begin
                    // whole address went out, so the alert is served
                    n.ctrl[`SMBAT_C_ALERT] = 1'h0; // RULE_11
                    n.st = S_IDLE;
                end
            default:
                n.st = S_IDLE;
        endcase

        // start and stop restart the monitor from any state
        if (start_c)
        begin
            n.st = S_ADDR;
            n.bcnt = 4'h0;
            n.sda_oe_n = 1'h1;
        end
        else if (stop_c)
        begin
            n.st = S_IDLE;
            n.sda_oe_n = 1'h1;
        end
        if (!mon_on)
        begin
            n.st = S_IDLE;
            n.sda_oe_n = 1'h1;
        end

        // disabling drops a pending alert request
        if (!r.ctrl[`SMBAT_C_EN])
            n.ctrl[`SMBAT_C_ALERT] = 1'h0; // RULE_22
        n.alert_oe_n = !n.ctrl[`SMBAT_C_ALERT]; // RULE_05

        // interrupt merge from registered status flags and the live buffer flag inputs
        n.evt_irq = r.irqen[`SMBAT_I_EVT] && ((|r.stat[4:0])
            || (r.irqen[`SMBAT_I_BUF] && (rx_buffer_full_flag
            || tx_buffer_empty_flag))); // RULE_18 RULE_19
        n.err_irq = r.irqen[`SMBAT_I_ERR]
            && (|r.stat[13:7]); // RULE_20
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r <= '0;
            r.ctrl <= `SMBAT_CTRL_RST;
            r.own <= `SMBAT_OWN_RST;
            r.div <= 13'(`SMBAT_HALF_MIN);
            r.wait_r <= 1'h1;
            r.scl_p <= 1'h1;
            r.sda_p <= 1'h1;
            r.st <= S_IDLE;
            r.sda_oe_n <= 1'h1;
            r.alert_oe_n <= 1'h1;
        end
        else
            r <= n;
    end

    // outputs straight from the state register, except sda_o and alert_o tied low
    assign avs_readdata = r.rdata;
    assign avs_waitrequest = r.wait_r;
    assign sda_o = 1'h0;
    assign alert_o = 1'h0;
    assign sda_oe_n = r.sda_oe_n;
    assign alert_oe_n = r.alert_oe_n;
    assign stop_request = r.ctrl[`SMBAT_C_STOP];
    assign scl_tick = r.tick;
    assign event_irq = r.evt_irq;
    assign fault_irq = r.err_irq;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_addr_end(logic [6:0] a);
        addr_done && r.sh[7:1] == a;
    endsequence
    sequence s_reply_done;
        r.st == S_MACK && rise;
    endsequence

    AST_TMO_FLAG: assert property ( // RULE_03
        tif.expired |=> r.stat[`SMBAT_S_TMO] && stop_request)
        else $error("timeout not flagged");
    AST_TMO_STOP: assert property ( // RULE_21
        tif.expired ##1 !stop_c |-> stop_request)
        else $error("timeout left stop request clear");
    AST_ARA_ACK: assert property ( // RULE_06
        s_addr_end(`SMBAT_ARA) and (r.ctrl[`SMBAT_C_ALERT] && mon_on
        && !start_c && !stop_c) |=> !sda_oe_n && r.st == S_ACK)
        else $error("alert response address not acknowledged");
    AST_ARA_IGNORE: assert property ( // RULE_07
        s_addr_end(`SMBAT_ARA) and !r.ctrl[`SMBAT_C_ALERT] |=> sda_oe_n)
        else $error("response address acked without alert");
    AST_DFLT: assert property ( // RULE_14
        dflt_hit && mon_on && !start_c && !stop_c
        |=> !sda_oe_n && r.stat[`SMBAT_S_DFLTM])
        else $error("default address not acked or flagged");
    AST_HOST: assert property ( // RULE_16
        host_hit |=> r.stat[`SMBAT_S_HOSTM])
        else $error("host header match not flagged");
    AST_DELIVER: assert property ( // RULE_11
        s_reply_done and !debug_halt |=> !r.ctrl[`SMBAT_C_ALERT]
        ##1 alert_oe_n)
        else $error("alert still driven after delivery");
    AST_LOSE: assert property ( // RULE_10
        r.st == S_SEND && rise && r.tx[7] && !sda_s && !start_c
        |=> r.st == S_IDLE && sda_oe_n)
        else $error("did not back off after lost arbitration");
    AST_DISABLE: assert property ( // RULE_22
        !r.ctrl[`SMBAT_C_EN] |=> alert_oe_n ##1 alert_oe_n)
        else $error("alert driven while disabled");
    AST_EVT_IRQ: assert property ( // RULE_18
        r.irqen[`SMBAT_I_EVT] && |r.stat[4:0] |=> event_irq)
        else $error("event interrupt missing");
    AST_BUF_IRQ: assert property ( // RULE_19
        !r.irqen[`SMBAT_I_BUF] && r.stat[4:0] == 5'h0 |=> !event_irq)
        else $error("buffer flags raised event without enable");
    AST_ERR_IRQ: assert property ( // RULE_20
        r.irqen[`SMBAT_I_ERR] == |r.stat[13:7] |=> fault_irq
        == $past(r.irqen[`SMBAT_I_ERR]))
        else $error("fault interrupt wrong");
    AST_DIV: assert property ( // RULE_04
        r.div >= 13'(`SMBAT_HALF_MIN) && r.div <= 13'(`SMBAT_HALF_MAX))
        else $error("clock half period out of range");
endmodule
`default_nettype wire

// [smbat_host.sv]
// smbus host model: bit-banged clock and data, 160 ns bit period
// assumes the block pulls data low only while sda_oe_n is low
`timescale 1ns/1ps
`default_nettype none
module smbat_host (
    input wire logic clk_sys,
    input wire logic sda_oe_n,
    output logic scl,
    output wire logic sda
);
    logic sda_drv = 1'b1;
    // pull-up on the wired-and data line
    assign sda = sda_drv & sda_oe_n;
    initial
        scl = 1'b1;
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // data moves mid-low so it never races the clock edge
    task automatic bit_io(input logic b, output logic r);
        wt(4);
        sda_drv <= b;
        wt(4);
        scl <= 1'b1;
        wt(8);
        r = sda;
        scl <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r[i]);
    endtask
    task automatic start();
        sda_drv <= 1'b0;
        wt(8);
        scl <= 1'b0;
    endtask
    task automatic stop();
        wt(4);
        sda_drv <= 1'b0;
        wt(4);
        scl <= 1'b1;
        wt(8);
        sda_drv <= 1'b1;
        wt(8);
    endtask
    // clock held low for n cycles, then released
    task automatic low(input int n);
        scl <= 1'b0;
        wt(n);
        scl <= 1'b1;
        wt(8);
    endtask
endmodule
`default_nettype wire

// [tb_smbat_top.sv]
// self-checking bench of the smbus alert, timeout and irq merge block
// assumes the host model is compiled first; timeout shortened to 200
`timescale 1ns/1ps
`default_nettype none
module tb_smbat_top;
    logic clk_sys = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00, evt_set = 5'h00, err_set = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, scl_i, sda_i, sda_oe_n, alert_oe_n, v;
    logic alert_ext = 1'b1, rx_f = 1'b0, tx_f = 1'b0, debug_halt = 1'b0;
    logic stop_request, event_irq, fault_irq, scl_tick;
    logic [7:0] r;
    int error_cnt = 0, comparisons = 0, t = 0;
    // alert is wired-and of the block and an outside device
    wire alert_i = alert_oe_n & alert_ext;
    always #5 clk_sys = ~clk_sys;
    smbat_top #(.TLOW_CYC(200)) smbat_top_i (.clk_sys, .arst_n,
        .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .scl_i, .sda_i, .sda_o(),
        .sda_oe_n, .alert_i, .alert_o(), .alert_oe_n, .evt_set, .err_set,
        .rx_buffer_full_flag(rx_f), .tx_buffer_empty_flag(tx_f),
        .debug_halt, .stop_request, .scl_tick, .event_irq, .fault_irq);
    smbat_host smbat_host_i (.clk_sys, .sda_oe_n, .scl(scl_i),
        .sda(sda_i));
    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, e);
        comparisons++;
        if (got !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, got);
        end
    endtask
    // one avalon access; held until waitrequest is seen low
    task automatic acc(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        // waitrequest and read data are taken at the same rising edge
        do
            @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && ++n < 40);
        if (n >= 40)
        begin
            error_cnt++;
            stop_test();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] e,
        input string nm);
        acc(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    // host addresses one byte and returns the ack bit in v
    task automatic addr(input logic [7:0] b);
        smbat_host_i.start();
        smbat_host_i.byte_io(b, r);
        smbat_host_i.bit_io(1'b1, v);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rc(5'h00, 32'h0, "ctrl");
        rc(5'h10, 32'h0000_01F4, "div");
        rc(5'h14, 32'h0, "unmapped");
        wr(5'h10, 32'h0000_1FFF);
        rc(5'h10, 32'h0000_1388, "div_hi");
        wr(5'h10, 32'h0000_0001);
        rc(5'h10, 32'h0000_01F4, "div_lo");
        // each event and error source alone raises its line
        wr(5'h04, 32'h0000_0005);
        for (int i = 0; i < 5; i++)
        begin
            evt_set <= 5'(1 << i);
            err_set <= 5'(1 << i);
            @(posedge clk_sys);
            evt_set <= 5'h00;
            err_set <= 5'h00;
            repeat (3) @(negedge clk_sys);
            chk("evt_irq", event_irq, 1'b1);
            chk("err_irq", fault_irq, 1'b1);
            @(posedge clk_sys);
            wr(5'h08, 32'h0000_FF9F);
            @(negedge clk_sys);
            chk("irq_clr", {event_irq, fault_irq}, 2'b00);
            @(posedge clk_sys);
        end
        // buffer flag needs the buffer enable as well
        rx_f <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("buf_gate", event_irq, 1'b0);
        @(posedge clk_sys);
        wr(5'h04, 32'h0000_0007);
        @(negedge clk_sys);
        chk("buf_irq", event_irq, 1'b1);
        @(posedge clk_sys);
        rx_f <= 1'b0;
        wr(5'h04, 32'h0000_0004);
        wr(5'h00, 32'h0000_0003);
        // divider ticks lie one half period apart
        t = 0;
        while (scl_tick !== 1'b1 && t < 600)
        begin
            @(posedge clk_sys);
            t++;
        end
        @(posedge clk_sys);
        t = 1;
        while (scl_tick !== 1'b1 && t < 600)
        begin
            @(posedge clk_sys);
            t++;
        end
        chk("tick_gap", t, 32'h0000_01F4);
        smbat_host_i.low(190);
        rc(5'h08, 32'h0, "short_low");
        debug_halt <= 1'b1;
        wr(5'h00, 32'h0000_0043);
        smbat_host_i.low(260);
        rc(5'h08, 32'h0, "frozen");
        debug_halt <= 1'b0;
        smbat_host_i.low(260);
        rc(5'h08, 32'h0000_1000, "tmo");
        chk("stop_req", stop_request, 1'b1);
        chk("tmo_irq", fault_irq, 1'b1);
        wr(5'h08, 32'h0000_FF9F);
        // alert: reply with own address, then release
        wr(5'h0C, 32'h0000_002B);
        wr(5'h00, 32'h0000_0013);
        chk("alert_low", alert_oe_n, 1'b0);
        addr(8'h19);
        chk("ara_ack", v, 1'b0);
        smbat_host_i.byte_io(8'hFF, r);
        chk("reply", r, 8'h56);
        smbat_host_i.bit_io(1'b1, v);
        smbat_host_i.stop();
        chk("alert_free", alert_oe_n, 1'b1);
        rc(5'h00, 32'h0000_0003, "alert_bit");
        addr(8'h19);
        chk("ara_nak", v, 1'b1);
        smbat_host_i.stop();
        // default device address, then host header and alert flag
        wr(5'h00, 32'h0000_000B);
        addr(8'hC2);
        chk("dflt_ack", v, 1'b0);
        smbat_host_i.stop();
        rc(5'h08, 32'h0000_8000, "dflt_flag");
        wr(5'h08, 32'h0000_FF9F);
        wr(5'h00, 32'h0000_000F);
        addr(8'h10);
        chk("host_ack", v, 1'b0);
        smbat_host_i.stop();
        alert_ext <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rc(5'h08, 32'h0000_6000, "host_flags");
        chk("alert_irq", fault_irq, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
